// ==== hdl/supply_cmd_pkg.sv ====
// shared codes, limits and timing for the supply remote command block
//======================================================================
// How it works
// - output-changing commands restart that output's settle delay
// - settle delay hides regulation status from fault logic
// - settle delay resets to 20 ms
// - delay 0 to 32 s, rounded to 4 ms
// - out-of-range delay rejected, setting kept, error recorded
// - delay query returns the output's setting
// - display command 0 off, 1 on; query returns it
// - message up to twelve upper, digit, space chars
// - message over twelve chars records code 7
// - any error sets indicator and poll error flag
// - error query returns code, then clears flag
// - code 0 none pending, 1 bad character
// - code 2 bad number, 3 or 28 unknown command
// - code 4 syntax, 5 number out of range
// - code 6 talk without a preceding query
// - code 8 buffer, 9 eeprom, 10 unknown output
// - model query answers the model number
// - self-test query checks digital parts, returns code
// - calibration query answers 1 on, 0 off
// - power-on output state selects 0 to 3
// - states 0,1 turn off in voltage mode
// - states 2,3 turn off in current mode
// - error flag is poll register bit 5
// - self-test codes 0,20,21,27,29,30
package supply_cmd_pkg;
  // command codes from the parser
  localparam int CMD_W = 4;
  localparam logic [3:0] CMD_NONE = 4'h0;
  localparam logic [3:0] CMD_VOLT_SET = 4'h1;
  localparam logic [3:0] CMD_CURR_SET = 4'h2;
  localparam logic [3:0] CMD_RECALL = 4'h3;
  localparam logic [3:0] CMD_OV_CLEAR = 4'h4;
  localparam logic [3:0] CMD_OC_CLEAR = 4'h5;
  localparam logic [3:0] CMD_OUT_ONOFF = 4'h6;
  localparam logic [3:0] CMD_SETTLE_SET = 4'h7;
  localparam logic [3:0] CMD_SETTLE_QRY = 4'h8;
  localparam logic [3:0] CMD_DISP_SET = 4'h9;
  localparam logic [3:0] CMD_DISP_QRY = 4'hA;
  localparam logic [3:0] CMD_ERR_QRY = 4'hB;
  localparam logic [3:0] CMD_MODEL_QRY = 4'hC;
  localparam logic [3:0] CMD_TEST_QRY = 4'hD;
  localparam logic [3:0] CMD_CAL_QRY = 4'hE;
  localparam logic [3:0] CMD_PON_SET = 4'hF;
  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam int STEP_MS = 4;
  localparam int unsigned STEP_CYCLES = STEP_MS * (CLK_HZ / 1000);
  localparam int STEP_W = 13;
  localparam int DLY_MAX_S = 32;
  localparam logic [16:0] DLY_MAX_MS = 17'(DLY_MAX_S * 1000);
  localparam int DLY_RESET_MS = 20;
  localparam logic [STEP_W-1:0] DLY_RESET_STEPS = STEP_W'(DLY_RESET_MS / STEP_MS);
  // error and self-test codes
  localparam logic [4:0] ERR_NONE = 5'h00;
  localparam logic [4:0] ERR_RANGE = 5'h05;
  localparam logic [4:0] ERR_DISP_LEN = 5'h07;
  localparam logic [4:0] TST_PASS = 5'h00;
  localparam logic [4:0] TST_TIMER = 5'h14;
  localparam logic [4:0] TST_RAM = 5'h15;
  localparam logic [4:0] TST_ROM = 5'h1B;
  localparam logic [4:0] TST_NV_SUM = 5'h1D;
  localparam logic [4:0] TST_STORE = 5'h1E;
  localparam int TF_TIMER = 0;
  localparam int TF_RAM = 1;
  localparam int TF_ROM = 2;
  localparam int TF_NV_SUM = 3;
  localparam int TF_STORE = 4;
  // poll register, status lanes, display, power-on state
  localparam int SPOLL_ERR_BIT = 5;
  localparam int ST_W = 4;
  localparam int MSG_LEN = 12;
  localparam logic [7:0] CHAR_SPACE = 8'h20;
  localparam logic [15:0] DISP_MAX_ARG = 16'h0001;
  localparam logic [15:0] PON_MAX_ARG = 16'h0003;
  localparam logic [1:0] PON_RESET = 2'h0;
  localparam logic [15:0] MODEL_DEFAULT = 16'h1234; // arbitrary value
endpackage

// ==== hdl/msg_capture.sv ====
// front-panel message capture: filters, counts and commits a quoted string
module msg_capture #(
  parameter int LEN = supply_cmd_pkg::MSG_LEN
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic char_valid_i,
  input wire logic [7:0] char_i,
  input wire logic end_i,
  output logic [8*LEN-1:0] msg_o,
  output logic msg_load_o,
  output logic too_long_o
);
  import supply_cmd_pkg::*;

  localparam int CNT_W = $clog2(LEN + 2);

  //======================================================================
  // character filter
  // anything the panel cannot draw becomes a blank
  function automatic logic [7:0] shown(input logic [7:0] c);
    logic ok;
    ok = (c >= 8'h41 && c <= 8'h5A) || (c >= 8'h30 && c <= 8'h39) || c == CHAR_SPACE;
    return ok ? c : CHAR_SPACE;
  endfunction

  logic [7:0] stage [LEN];
  logic [CNT_W-1:0] count;
  logic active;
  logic room;
  logic finish;

  assign room = count < CNT_W'(LEN);
  assign finish = active & end_i & ~start_i;

  //======================================================================
  // staging, count saturates one past the limit
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      active <= 1'b0;
      count <= '0;
      for (int i = 0; i < LEN; i++) begin
        stage[i] <= CHAR_SPACE;
      end
    end else if (start_i) begin
      active <= 1'b1;
      count <= '0;
      for (int i = 0; i < LEN; i++) begin
        stage[i] <= CHAR_SPACE;
      end
    end else if (finish) begin
      active <= 1'b0;
    end else if (active && char_valid_i) begin
      if (room) begin
        stage[count] <= shown(char_i);
      end
      if (count <= CNT_W'(LEN)) begin
        count <= count + 1'b1;
      end
    end
  end

  //======================================================================
  // commit: an over-long string leaves the old message standing
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      msg_o <= {LEN{CHAR_SPACE}};
      msg_load_o <= 1'b0;
      too_long_o <= 1'b0;
    end else begin
      msg_load_o <= finish & room | finish & (count == CNT_W'(LEN));
      too_long_o <= finish & (count > CNT_W'(LEN));
      if (finish && count <= CNT_W'(LEN)) begin
        for (int i = 0; i < LEN; i++) begin
          msg_o[8*i +: 8] <= stage[i];
        end
      end
    end
  end
endmodule

// ==== hdl/supply_remote_command_status.sv ====
// remote command handling: settle delay, display, error code, queries
module supply_remote_command_status #(
  parameter int NUM_OUT = 4,
  parameter int unsigned STEP_CYCLES = supply_cmd_pkg::STEP_CYCLES,
  parameter logic [15:0] MODEL_NUM = supply_cmd_pkg::MODEL_DEFAULT, // arbitrary value
  parameter logic [1:0] PON_INIT = supply_cmd_pkg::PON_RESET
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cmd_valid_i,
  input wire logic [supply_cmd_pkg::CMD_W-1:0] cmd_code_i,
  input wire logic [$clog2(NUM_OUT)-1:0] cmd_chan_i,
  input wire logic [15:0] cmd_arg_i,
  input wire logic msg_start_i,
  input wire logic msg_char_valid_i,
  input wire logic [7:0] msg_char_i,
  input wire logic msg_end_i,
  input wire logic err_event_i,
  input wire logic [4:0] err_code_i,
  input wire logic [supply_cmd_pkg::ST_W*NUM_OUT-1:0] status_i,
  input wire logic cal_mode_i,
  input wire logic [4:0] test_fail_i,
  output logic [supply_cmd_pkg::ST_W*NUM_OUT-1:0] status_gated_o,
  output logic [NUM_OUT-1:0] settle_busy_o,
  output logic resp_valid_o,
  output logic [15:0] resp_data_o,
  output logic err_flag_o,
  output logic [4:0] err_code_o,
  output logic [7:0] spoll_err_bits_o,
  output logic display_on_o,
  output logic [8*supply_cmd_pkg::MSG_LEN-1:0] msg_o,
  output logic msg_update_o,
  output logic [1:0] pon_state_o,
  output logic off_neg_current_o
);
  import supply_cmd_pkg::*;

  localparam int CH_W = $clog2(NUM_OUT);

  //======================================================================
  // helpers
  function automatic logic [15:0] steps_to_ms(input logic [STEP_W-1:0] s);
    return 16'(s) * 16'(STEP_MS);
  endfunction

  function automatic logic [4:0] test_result(input logic [4:0] f);
    if (f[TF_TIMER]) return TST_TIMER;
    if (f[TF_RAM]) return TST_RAM;
    if (f[TF_ROM]) return TST_ROM;
    if (f[TF_NV_SUM]) return TST_NV_SUM;
    if (f[TF_STORE]) return TST_STORE;
    return TST_PASS;
  endfunction

  function automatic logic is_cmd(input logic v, input logic [3:0] c, input logic [3:0] want);
    return v && c == want;
  endfunction

  //======================================================================
  // command decode
  logic trig_one;
  logic trig_all;
  logic dly_set;
  logic dly_query;
  logic dsp_set;
  logic dsp_query;
  logic err_query;
  logic model_query;
  logic test_query;
  logic cal_query;
  logic pon_set;
  logic any_query;
  logic chan_bad;

  assign trig_one = is_cmd(cmd_valid_i, cmd_code_i, CMD_VOLT_SET) | is_cmd(cmd_valid_i, cmd_code_i, CMD_CURR_SET)
                  | is_cmd(cmd_valid_i, cmd_code_i, CMD_OV_CLEAR) | is_cmd(cmd_valid_i, cmd_code_i, CMD_OC_CLEAR)
                  | is_cmd(cmd_valid_i, cmd_code_i, CMD_OUT_ONOFF);
  assign trig_all = is_cmd(cmd_valid_i, cmd_code_i, CMD_RECALL); // recall touches every output
  assign dly_set = is_cmd(cmd_valid_i, cmd_code_i, CMD_SETTLE_SET);
  assign dly_query = is_cmd(cmd_valid_i, cmd_code_i, CMD_SETTLE_QRY);
  assign dsp_set = is_cmd(cmd_valid_i, cmd_code_i, CMD_DISP_SET);
  assign dsp_query = is_cmd(cmd_valid_i, cmd_code_i, CMD_DISP_QRY);
  assign err_query = is_cmd(cmd_valid_i, cmd_code_i, CMD_ERR_QRY);
  assign model_query = is_cmd(cmd_valid_i, cmd_code_i, CMD_MODEL_QRY);
  assign test_query = is_cmd(cmd_valid_i, cmd_code_i, CMD_TEST_QRY);
  assign cal_query = is_cmd(cmd_valid_i, cmd_code_i, CMD_CAL_QRY);
  assign pon_set = is_cmd(cmd_valid_i, cmd_code_i, CMD_PON_SET);
  assign any_query = dly_query | dsp_query | err_query | model_query | test_query | cal_query;
  assign chan_bad = {1'b0, cmd_chan_i} >= (CH_W + 1)'(NUM_OUT); // one spare bit so NUM_OUT itself fits

  //======================================================================
  // argument checks; rounding adds half a step before truncation
  logic [16:0] dly_round_sum;
  logic [STEP_W-1:0] dly_steps_new;
  logic dly_bad;
  logic dly_ok;
  logic dsp_bad;
  logic pon_bad;
  logic msg_too_long;

  assign dly_round_sum = {1'b0, cmd_arg_i} + 17'h00002;
  assign dly_steps_new = dly_round_sum[STEP_W+1:2];
  assign dly_bad = (dly_set | dly_query) & chan_bad | dly_set & ({1'b0, cmd_arg_i} > DLY_MAX_MS);
  assign dly_ok = dly_set & ~dly_bad;
  assign dsp_bad = dsp_set & (cmd_arg_i > DISP_MAX_ARG);
  assign pon_bad = pon_set & (cmd_arg_i > PON_MAX_ARG);

  //======================================================================
  // per-output settle delay: counts clock cycles so the hold is exact
  logic [STEP_W-1:0] settle_steps [NUM_OUT];
  logic [31:0] settle_left [NUM_OUT];
  wire [ST_W*NUM_OUT-1:0] busy_mask;

  for (genvar g = 0; g < NUM_OUT; g++) begin : g_out
    wire start = trig_all | trig_one & (cmd_chan_i == CH_W'(g));
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        settle_steps[g] <= DLY_RESET_STEPS;
        settle_left[g] <= 32'h0;
      end else begin
        if (dly_ok && cmd_chan_i == CH_W'(g)) begin
          settle_steps[g] <= dly_steps_new;
        end
        if (start) begin
          settle_left[g] <= 32'(settle_steps[g]) * STEP_CYCLES;
        end else if (settle_left[g] != 32'h0) begin
          settle_left[g] <= settle_left[g] - 32'h1;
        end
      end
    end
    assign settle_busy_o[g] = settle_left[g] != 32'h0;
    assign busy_mask[g*ST_W +: ST_W] = {ST_W{settle_busy_o[g]}};
  end

  // regulation lanes are zeroed while their output settles
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_gated_o <= '0;
    end else begin
      status_gated_o <= status_i & ~busy_mask;
    end
  end

  //======================================================================
  // display message buffer
  msg_capture #(.LEN(MSG_LEN)) u_msg (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(msg_start_i),
    .char_valid_i(msg_char_valid_i),
    .char_i(msg_char_i),
    .end_i(msg_end_i),
    .msg_o(msg_o),
    .msg_load_o(msg_update_o),
    .too_long_o(msg_too_long)
  );

  //======================================================================
  // error code register; local errors outrank parser errors in one cycle
  logic int_err;
  logic [4:0] int_code;
  logic new_err;
  logic [4:0] new_code;

  assign int_err = dly_bad | dsp_bad | pon_bad | msg_too_long;
  assign int_code = msg_too_long ? ERR_DISP_LEN : ERR_RANGE;
  assign new_err = int_err | err_event_i;
  assign new_code = int_err ? int_code : err_code_i;

  // a fresh error in the read cycle survives the clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      err_flag_o <= 1'b0;
      err_code_o <= ERR_NONE;
    end else if (new_err) begin
      err_flag_o <= 1'b1;
      err_code_o <= new_code;
    end else if (err_query) begin
      err_flag_o <= 1'b0;
      err_code_o <= ERR_NONE;
    end
  end

  assign spoll_err_bits_o = 8'(err_flag_o) << SPOLL_ERR_BIT;

  //======================================================================
  // display switch and power-on output state
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      display_on_o <= 1'b1;
      pon_state_o <= PON_INIT;
    end else begin
      if (dsp_set && !dsp_bad) begin
        display_on_o <= cmd_arg_i[0];
      end
      if (pon_set && !pon_bad) begin
        pon_state_o <= cmd_arg_i[1:0];
      end
    end
  end

  // states 2 and 3 park an off output in current mode
  assign off_neg_current_o = pon_state_o[1];

  //======================================================================
  // query answers, one cycle after the command
  logic [STEP_W-1:0] sel_steps;
  logic [15:0] next_resp_data;

  assign sel_steps = chan_bad ? '0 : settle_steps[cmd_chan_i];

  always_comb begin
    next_resp_data = 16'h0000;
    case (cmd_code_i)
      CMD_SETTLE_QRY: next_resp_data = steps_to_ms(sel_steps);
      CMD_DISP_QRY: next_resp_data = 16'(display_on_o);
      CMD_ERR_QRY: next_resp_data = 16'(err_code_o);
      CMD_MODEL_QRY: next_resp_data = MODEL_NUM;
      CMD_TEST_QRY: next_resp_data = 16'(test_result(test_fail_i));
      CMD_CAL_QRY: next_resp_data = 16'(cal_mode_i);
      default: next_resp_data = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      resp_valid_o <= 1'b0;
      resp_data_o <= 16'h0000;
    end else begin
      resp_valid_o <= any_query;
      resp_data_o <= any_query ? next_resp_data : resp_data_o;
    end
  end

  //======================================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic seen_set0;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      seen_set0 <= 1'b0;
    end else if (dly_ok && cmd_chan_i == '0) begin
      seen_set0 <= 1'b1;
    end
  end

  property p_settle_start;
    trig_one && cmd_chan_i == '0 && settle_steps[0] != '0 |=> settle_busy_o[0] [*2];
  endproperty
  a_settle_start: assert property (p_settle_start) else $error("settle delay did not start");

  property p_settle_mask;
    settle_busy_o[0] |=> status_gated_o[ST_W-1:0] == '0;
  endproperty
  a_settle_mask: assert property (p_settle_mask) else $error("status leaked during settle");

  property p_reset_delay;
    dly_query && cmd_chan_i == '0 && !seen_set0 |=> resp_data_o == 16'h0014;
  endproperty
  a_reset_delay: assert property (p_reset_delay) else $error("power-on delay not 20 ms");

  property p_round;
    logic [16:0] a;
    (dly_ok && cmd_chan_i == '0, a = {1'b0, cmd_arg_i})
      |=> {1'b0, steps_to_ms(settle_steps[0])} + 17'h00002 >= a && {1'b0, steps_to_ms(settle_steps[0])} <= a + 17'h00002;
  endproperty
  a_round: assert property (p_round) else $error("delay not rounded to nearest step");

  property p_range_reject;
    dly_set && cmd_chan_i == '0 && cmd_arg_i > 16'h7D00 |=> settle_steps[0] == $past(settle_steps[0]) && err_flag_o;
  endproperty
  a_range_reject: assert property (p_range_reject) else $error("bad delay accepted");

  property p_query_span;
    dly_query |=> resp_valid_o && resp_data_o <= 16'h7D00;
  endproperty
  a_query_span: assert property (p_query_span) else $error("delay answer out of span");

  property p_display;
    dsp_set && cmd_arg_i == 16'h0000 |=> !display_on_o ##1 (resp_data_o == 16'h0000 || !$past(dsp_query));
  endproperty
  a_display: assert property (p_display) else $error("display not switched off");

  property p_len_err;
    msg_too_long |=> err_code_o == ERR_DISP_LEN && err_flag_o;
  endproperty
  a_len_err: assert property (p_len_err) else $error("long message not flagged");

  property p_err_answer;
    err_query |=> resp_valid_o && resp_data_o == 16'($past(err_code_o));
  endproperty
  a_err_answer: assert property (p_err_answer) else $error("error answer wrong");

  property p_err_clear;
    err_query && !new_err |=> !err_flag_o && err_code_o == ERR_NONE && spoll_err_bits_o == 8'h00;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error not cleared by query");

  property p_err_bit;
    new_err |=> spoll_err_bits_o == 8'h20;
  endproperty
  a_err_bit: assert property (p_err_bit) else $error("poll error bit missing");

  property p_cal;
    cal_query |=> resp_data_o == 16'($past(cal_mode_i));
  endproperty
  a_cal: assert property (p_cal) else $error("calibration answer wrong");

  property p_off_mode;
    pon_set && !pon_bad |=> off_neg_current_o == $past(cmd_arg_i[1]);
  endproperty
  a_off_mode: assert property (p_off_mode) else $error("off mode not following state");

  property p_test;
    test_query && test_fail_i[TF_TIMER] |=> resp_data_o == 16'h0014;
  endproperty
  a_test: assert property (p_test) else $error("timer failure code wrong");

  c_settle_done: cover property (settle_busy_o[0] ##1 !settle_busy_o[0]);
  c_msg_load: cover property (msg_update_o);
  c_err_read: cover property (err_query && err_flag_o);
  c_err_race: cover property (err_query && new_err);
endmodule

// ==== verif/bus_ctrl_model.sv ====
// bus controller model: presents one command per request, otherwise drives valid low and the inverse of the last command
module bus_ctrl_model (
  input wire logic go_i,
  input wire logic [3:0] code_i,
  input wire logic [1:0] chan_i,
  input wire logic [15:0] arg_i,
  output logic cmd_valid_o,
  output logic [3:0] cmd_code_o,
  output logic [1:0] cmd_chan_o,
  output logic [15:0] cmd_arg_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [21:0] last = 22'h0;
  //======================================================================
  // released lines
  // remember the last command so an idle bus never shows a stale value
  always @(go_i or code_i or chan_i or arg_i) begin
    if (go_i) begin
      last = {code_i, chan_i, arg_i};
    end
  end
  // each query is sent before the device is asked to answer
  assign cmd_valid_o = go_i;
  assign {cmd_code_o, cmd_chan_o, cmd_arg_o} = go_i ? {code_i, chan_i, arg_i} : ~last;
endmodule

// ==== verif/supply_remote_command_status_bench.sv ====
// self-checking bench for the supply remote command block
module supply_remote_command_status_bench;
  import supply_cmd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int STEP = 4;
  logic clk_i = 1'b0, rst_i = 1'b1, go = 1'b0;
  logic [3:0] code = 4'h0;
  logic [1:0] chan = 2'h0;
  logic [15:0] arg = 16'h0;
  logic cmd_valid, msg_start_i = 1'b0, msg_char_valid_i = 1'b0, msg_end_i = 1'b0;
  logic [3:0] cmd_code;
  logic [1:0] cmd_chan;
  logic [15:0] cmd_arg;
  logic [7:0] msg_char_i = 8'h00;
  logic err_event_i = 1'b0, cal_mode_i = 1'b0;
  logic [4:0] err_code_i = 5'h00, test_fail_i = 5'h00;
  logic [15:0] status_i = 16'hFFFF, status_gated_o, resp_data_o;
  logic [3:0] settle_busy_o;
  logic resp_valid_o, err_flag_o, display_on_o, msg_update_o, off_neg_current_o;
  logic [4:0] err_code_o;
  logic [7:0] spoll_err_bits_o;
  logic [95:0] msg_o;
  logic [1:0] pon_state_o;
  int num_errors = 0, samples_checked = 0, n;
  logic [4:0] errs [9] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h09, 5'h0A, 5'h1C};
  logic [4:0] fails [8] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h1F, 5'h1C};
  logic [4:0] tcode [8] = '{5'h00, 5'h14, 5'h15, 5'h1B, 5'h1D, 5'h1E, 5'h14, 5'h1B};
  logic [3:0] trig [5] = '{CMD_VOLT_SET, CMD_CURR_SET, CMD_OV_CLEAR, CMD_OC_CLEAR, CMD_OUT_ONOFF};

  bus_ctrl_model i_bus_ctrl_model (.go_i(go), .code_i(code), .chan_i(chan), .arg_i(arg),
    .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code), .cmd_chan_o(cmd_chan), .cmd_arg_o(cmd_arg));
  supply_remote_command_status #(.STEP_CYCLES(STEP)) i_supply_remote_command_status (
    .clk_i(clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code),
    .cmd_chan_i(cmd_chan), .cmd_arg_i(cmd_arg), .msg_start_i(msg_start_i),
    .msg_char_valid_i(msg_char_valid_i), .msg_char_i(msg_char_i), .msg_end_i(msg_end_i),
    .err_event_i(err_event_i), .err_code_i(err_code_i), .status_i(status_i), .cal_mode_i(cal_mode_i),
    .test_fail_i(test_fail_i), .status_gated_o(status_gated_o), .settle_busy_o(settle_busy_o),
    .resp_valid_o(resp_valid_o), .resp_data_o(resp_data_o), .err_flag_o(err_flag_o),
    .err_code_o(err_code_o), .spoll_err_bits_o(spoll_err_bits_o), .display_on_o(display_on_o),
    .msg_o(msg_o), .msg_update_o(msg_update_o), .pon_state_o(pon_state_o),
    .off_neg_current_o(off_neg_current_o));

  //======================================================================
  // clock, shared tasks
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  task automatic finish_test;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [95:0] got, input logic [95:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  // command lasts one cycle; results are read at the following falling edge
  task automatic cmd(input logic [3:0] c, input logic [1:0] ch, input logic [15:0] a);
    @(negedge clk_i);
    go = 1'b1;
    code = c;
    chan = ch;
    arg = a;
    @(negedge clk_i);
    go = 1'b0;
  endtask
  task automatic query(input logic [3:0] c, input logic [1:0] ch, input logic [15:0] exp);
    cmd(c, ch, 16'h0);
    chk(resp_valid_o, 1'b1, "answer strobe");
    chk(resp_data_o, exp, "answer data");
  endtask
  // counts busy cycles; the lane must be masked once the count is running
  task automatic settle(input logic [3:0] c, input logic [1:0] ch, input int steps);
    n = 0;
    cmd(c, ch, 16'h0);
    while (settle_busy_o[ch] === 1'b1 && n < 400) begin
      n++;
      if (n == 2) begin
        chk(status_gated_o[4*ch +: 4], 4'h0, "masked lane");
      end
      @(negedge clk_i);
    end
    chk(n, steps * STEP, "busy length");
    // the gated copy is registered, so the lane reopens one cycle after busy drops
    @(negedge clk_i);
    chk(status_gated_o, 16'hFFFF, "lanes restored");
  endtask
  task automatic err_clear(input logic [4:0] c);
    query(CMD_ERR_QRY, 2'h0, {11'h0, c});
    chk({err_flag_o, err_code_o, spoll_err_bits_o}, 14'h0, "error cleared");
  endtask
  task automatic msg(input string s);
    @(negedge clk_i);
    msg_start_i = 1'b1;
    foreach (s[i]) begin
      @(negedge clk_i);
      msg_start_i = 1'b0;
      msg_char_valid_i = 1'b1;
      msg_char_i = s[i];
    end
    @(negedge clk_i);
    msg_char_valid_i = 1'b0;
    msg_end_i = 1'b1;
    @(negedge clk_i);
    msg_end_i = 1'b0;
  endtask

  //======================================================================
  // watchdog, far beyond the expected run of about three hundred cycles
  initial begin
    #1000000;
    num_errors++;
    finish_test();
  end

  //======================================================================
  // tests
  initial begin
    repeat (16) @(negedge clk_i);
    rst_i = 1'b0;
    chk({display_on_o, pon_state_o, err_flag_o, settle_busy_o}, 8'h80, "reset state");
    chk(msg_o, {12{8'h20}}, "reset message");
    query(CMD_SETTLE_QRY, 2'h0, 16'd20);
    settle(CMD_VOLT_SET, 2'h3, 5);
    // output 0 here, so the design's own delay checks watch these commands too
    cmd(CMD_SETTLE_SET, 2'h0, 16'd81);
    query(CMD_SETTLE_QRY, 2'h0, 16'd80);
    cmd(CMD_SETTLE_SET, 2'h0, 16'd83);
    query(CMD_SETTLE_QRY, 2'h0, 16'd84);
    cmd(CMD_SETTLE_SET, 2'h0, 16'd32000);
    cmd(CMD_SETTLE_SET, 2'h0, 16'd32001);
    chk({err_flag_o, err_code_o, spoll_err_bits_o}, {1'b1, 5'h05, 8'h20}, "range error");
    query(CMD_SETTLE_QRY, 2'h0, 16'd32000);
    err_clear(5'h05);
    cmd(CMD_SETTLE_SET, 2'h0, 16'd8);
    foreach (trig[i]) begin
      settle(trig[i], 2'h0, 2);
    end
    cmd(CMD_RECALL, 2'h0, 16'h0);
    chk(settle_busy_o, 4'hF, "recall starts all");
    repeat (24) @(negedge clk_i);
    cmd(CMD_SETTLE_SET, 2'h1, 16'd0);
    settle(CMD_CURR_SET, 2'h1, 0);
    // display switch and its refusal
    cmd(CMD_DISP_SET, 2'h0, 16'd0);
    query(CMD_DISP_QRY, 2'h0, 16'd0);
    chk(display_on_o, 1'b0, "display off");
    cmd(CMD_DISP_SET, 2'h0, 16'd1);
    query(CMD_DISP_QRY, 2'h0, 16'd1);
    cmd(CMD_DISP_SET, 2'h0, 16'd2);
    query(CMD_DISP_QRY, 2'h0, 16'd1);
    err_clear(5'h05);
    // message filtering, twelve fits, thirteen is refused
    msg("a1 ?Z");
    chk(msg_update_o, 1'b1, "message commit");
    chk(msg_o, {{7{8'h20}}, 40'h5A20203120}, "filtered message");
    msg("ABCDEFGHIJKL");
    chk(msg_o, 96'h4C4B4A494847464544434241, "full message");
    msg("ABCDEFGHIJKLM");
    chk(msg_update_o, 1'b0, "no commit");
    @(negedge clk_i);
    chk({err_flag_o, err_code_o}, {1'b1, 5'h07}, "length error");
    chk(msg_o, 96'h4C4B4A494847464544434241, "message kept");
    err_clear(5'h07);
    // external error codes, each held until the query reads it
    foreach (errs[i]) begin
      @(negedge clk_i);
      err_event_i = 1'b1;
      err_code_i = errs[i];
      @(negedge clk_i);
      err_event_i = 1'b0;
      chk({err_flag_o, err_code_o, spoll_err_bits_o}, {1'b1, errs[i], 8'h20}, "error latch");
      err_clear(errs[i]);
    end
    // a new error in the read cycle outlives the clear; the answer is the old code
    @(negedge clk_i);
    err_event_i = 1'b1;
    err_code_i = 5'h02;
    fork
      query(CMD_ERR_QRY, 2'h0, 16'h0002);
      begin
        @(negedge clk_i);
        err_code_i = 5'h03;
        @(negedge clk_i);
        err_event_i = 1'b0;
      end
    join
    chk({err_flag_o, err_code_o}, {1'b1, 5'h03}, "error survives read");
    err_clear(5'h03);
    err_clear(5'h00);
    query(CMD_MODEL_QRY, 2'h0, MODEL_DEFAULT);
    query(CMD_CAL_QRY, 2'h0, 16'd0);
    cal_mode_i = 1'b1;
    query(CMD_CAL_QRY, 2'h0, 16'd1);
    foreach (fails[i]) begin
      test_fail_i = fails[i];
      query(CMD_TEST_QRY, 2'h0, {11'h0, tcode[i]});
    end
    chk(settle_busy_o, 4'h0, "test leaves outputs alone");
    for (int p = 0; p < 4; p++) begin
      cmd(CMD_PON_SET, 2'h0, 16'(p));
      chk({pon_state_o, off_neg_current_o}, {2'(p), 1'(p >> 1)}, "power-on state");
    end
    cmd(CMD_PON_SET, 2'h0, 16'd4);
    chk(pon_state_o, 2'h3, "power-on kept");
    err_clear(5'h05);
    finish_test();
  end
endmodule
